// [verilog/sfp_pkg.sv]
// constants and types for the serial converter frame and power sequencer
// assumes: mclk at 125 MHz, link clock sclk from the host, 14-bit result
`default_nettype none

package sfp_pkg;

	// ------------------------------------------------------------------
	// frame geometry
	// ------------------------------------------------------------------
	localparam int RES_W = 14;
	localparam int WORD_W = 16;
	localparam int PAD_W = WORD_W - RES_W;
	localparam int CNT_W = 6;

	// sclk edge counts inside one chip select low period
	localparam logic [CNT_W-1:0] EDGE_START = 6'h01;
	localparam logic [CNT_W-1:0] EDGE_CONV = 6'h10;
	localparam logic [CNT_W-1:0] EDGE_MODE32 = 6'h1e;
	localparam logic [CNT_W-1:0] EDGE_WORD2_END = 6'h20;
	localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;

	localparam logic [RES_W-1:0] RES_ZERO = 14'h0000;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [PAD_W-1:0] PAD_ZERO = 2'h0;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int MCLK_MHZ = 125;
	localparam int WAKE_TIME_NS = 1000;
	// least time, rounded up to whole mclk cycles
	localparam int WAKE_CYC = (WAKE_TIME_NS * MCLK_MHZ + 999) / 1000;
	localparam int WAKE_W = 8;

	// ------------------------------------------------------------------
	// synchroniser lanes, link and pins into mclk
	// ------------------------------------------------------------------
	localparam int SY_CS = 0;
	localparam int SY_PDR = 1;
	localparam int SY_START = 2;
	localparam int SY_C16 = 3;
	localparam int SY_C30 = 4;
	localparam int SY_W = 5;
	// chip select idles high
	localparam logic [SY_W-1:0] SY_RST = 5'h01;

	// ------------------------------------------------------------------
	// power state
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		PWR_RUN = 3'b001,
		PWR_DOWN = 3'b010,
		PWR_WAKE = 3'b100
	} sfp_pwr_type;

endpackage

`default_nettype wire

// [verilog/sfp_sync.sv]
// two flip-flop synchroniser, one lane per bit
// assumes: each lane is a level that stays put for at least two clk cycles
`default_nettype none

module sfp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} sfp_sync_type;

	sfp_sync_type s_r;
	sfp_sync_type s_nxt;

	// ------------------------------------------------------------------
	// stages
	// ------------------------------------------------------------------
	// the first stage feeds only the second
	always_comb begin
		s_nxt.meta = d;
		s_nxt.q = s_r.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= {RST_VAL, RST_VAL};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.q;

endmodule

`default_nettype wire

// [verilog/sfp_core.sv]
// frame detection, conversion abort and power-down sequencing of a serial converter
// assumes: sclk and cs_n come from the host; sample_code is the held sample's
// decision word, stable while cs_n is low; cs_n high time of at least 8 mclk
`default_nettype none

module sfp_core
	import sfp_pkg::*;
#(
	parameter int WAKE_CYCLES = WAKE_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic power_down_request,
	input wire logic [sfp_pkg::RES_W-1:0] sample_code,
	output logic sdo,
	output logic sdo_oe,
	output logic sample_hold,
	output logic power_down,
	output logic powered_up,
	output logic frame_mode32,
	output logic frame_data_valid,
	output logic conv_abort
);

	import sfp_pkg::*;

	// ------------------------------------------------------------------
	// state types
	// ------------------------------------------------------------------
	// link side, cleared by the frame's own chip select
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic sdo;
		logic oe;
		logic f_start;
		logic f_c16;
		logic f_c30;
	} sfp_lnk_type;

	// link side, survives chip select so mclk can copy it at leisure
	typedef struct packed {
		logic [RES_W-1:0] conv;
	} sfp_cnv_type;

	// mclk side
	typedef struct packed {
		logic cs_q;
		logic start_q;
		logic seen16;
		logic seen30;
		logic [RES_W-1:0] conv_cp;
		logic [WORD_W-1:0] first_word;
		logic valid_next;
		logic pd_en;
		logic pd_armed;
		sfp_pwr_type pst;
		logic [WAKE_W-1:0] wake_cnt;
		logic hold;
		logic pdown;
		logic pup;
		logic mode32;
		logic dvalid;
		logic abort;
	} sfp_ctl_type;

	sfp_lnk_type lnk_r;
	sfp_lnk_type lnk_nxt;
	sfp_cnv_type cnv_r;
	sfp_cnv_type cnv_nxt;
	sfp_ctl_type ctl_r;
	sfp_ctl_type ctl_nxt;

	logic frame_rst_n;
	logic [SY_W-1:0] sy_d;
	logic [SY_W-1:0] sy_q;
	logic cs_s;
	logic pdr_s;
	logic start_s;
	logic c16_s;
	logic c30_s;
	logic cs_fall;
	logic cs_rise;
	logic start_rise;
	logic conv_done;
	logic [WAKE_W-1:0] wake_load;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// bit shown at a given edge index: stored word first, fresh word next, then zeros
	function automatic logic frame_bit(
		input logic [CNT_W-1:0] idx,
		input logic [WORD_W-1:0] w1,
		input logic [WORD_W-1:0] w2
	);
		logic b;
		b = 1'b0;
		if (idx < EDGE_CONV) begin
			b = w1[~idx[3:0]];
		end else if (idx < EDGE_WORD2_END) begin
			b = w2[~idx[3:0]];
		end
		return b;
	endfunction

	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
		return (c == CNT_MAX) ? c : c + EDGE_START;
	endfunction

	// ------------------------------------------------------------------
	// link domain: edge count and shift out
	// ------------------------------------------------------------------
	// cs_n high clears the frame state without any sclk edge, so a stopped
	// link clock between frames cannot leave stale count behind
	assign frame_rst_n = rst_n & ~cs_n;

	always_comb begin
		lnk_nxt = lnk_r;
		lnk_nxt.cnt = sat_inc(lnk_r.cnt);
		lnk_nxt.oe = 1'b1;
		// same timing whatever the power state
		lnk_nxt.sdo = frame_bit(lnk_r.cnt, ctl_r.first_word, {cnv_r.conv, PAD_ZERO});
		lnk_nxt.f_start = 1'b1;
		if (lnk_nxt.cnt >= EDGE_CONV) begin
			lnk_nxt.f_c16 = 1'b1;
		end
		if (lnk_nxt.cnt >= EDGE_MODE32) begin
			lnk_nxt.f_c30 = 1'b1;
		end
	end

	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			lnk_r <= '0;
		end else begin
			lnk_r <= lnk_nxt;
		end
	end

	// ------------------------------------------------------------------
	// link domain: conversion result
	// ------------------------------------------------------------------
	always_comb begin
		cnv_nxt = cnv_r;
		if (lnk_r.cnt == EDGE_CONV - EDGE_START) begin
			cnv_nxt.conv = sample_code;
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			cnv_r <= '0;
		end else begin
			cnv_r <= cnv_nxt;
		end
	end

	// ------------------------------------------------------------------
	// crossing into mclk
	// ------------------------------------------------------------------
	assign sy_d[SY_CS] = cs_n;
	assign sy_d[SY_PDR] = power_down_request;
	assign sy_d[SY_START] = lnk_r.f_start;
	assign sy_d[SY_C16] = lnk_r.f_c16;
	assign sy_d[SY_C30] = lnk_r.f_c30;

	sfp_sync #(
		.W(SY_W),
		.RST_VAL(SY_RST)
	) u_sync (
		.clk(mclk),
		.rst_n(rst_n),
		.d(sy_d),
		.q(sy_q)
	);

	assign cs_s = sy_q[SY_CS];
	assign pdr_s = sy_q[SY_PDR];
	assign start_s = sy_q[SY_START];
	assign c16_s = sy_q[SY_C16];
	assign c30_s = sy_q[SY_C30];

	assign cs_fall = ctl_r.cs_q & ~cs_s;
	assign cs_rise = ~ctl_r.cs_q & cs_s;
	assign start_rise = ~ctl_r.start_q & start_s;
	assign conv_done = c16_s & ~ctl_r.seen16 & ~cs_s;
	assign wake_load = WAKE_CYCLES[WAKE_W-1:0];

	// ------------------------------------------------------------------
	// mclk domain: frame type, abort, power
	// ------------------------------------------------------------------
	// the link flags rise at least one sclk edge before cs_n can rise, so the
	// sticky copies below are caught before the synchronised chip select
	// shows the rise; conv is stable from edge 16 until the next frame
	always_comb begin
		ctl_nxt = ctl_r;
		ctl_nxt.cs_q = cs_s;
		ctl_nxt.start_q = start_s;
		ctl_nxt.abort = 1'b0;

		if (conv_done) begin
			ctl_nxt.seen16 = 1'b1;
			ctl_nxt.conv_cp = cnv_r.conv;
			ctl_nxt.hold = 1'b0;
		end
		if (c30_s && !cs_s) begin
			ctl_nxt.seen30 = 1'b1;
		end

		if (cs_fall) begin
			ctl_nxt.hold = 1'b1;
			ctl_nxt.seen16 = 1'b0;
			ctl_nxt.seen30 = 1'b0;
			ctl_nxt.dvalid = ctl_r.valid_next;
		end

		if (cs_rise) begin
			ctl_nxt.pd_en = pdr_s;
			ctl_nxt.mode32 = ctl_r.seen30;
			if (!ctl_r.seen16) begin
				// result of the aborted frame never reaches the output
				ctl_nxt.hold = 1'b0;
				ctl_nxt.abort = 1'b1;
				ctl_nxt.valid_next = 1'b0;
				ctl_nxt.mode32 = 1'b0;
			end else if (ctl_r.seen30) begin
				ctl_nxt.first_word = WORD_ZERO;
				ctl_nxt.valid_next = 1'b1;
			end else begin
				ctl_nxt.first_word = {ctl_r.conv_cp, PAD_ZERO};
				ctl_nxt.valid_next = 1'b1;
			end
		end

		case (ctl_r.pst)
			PWR_RUN: begin
				ctl_nxt.pup = 1'b1;
			end
			PWR_DOWN: begin
				if (cs_rise && !pdr_s) begin
					ctl_nxt.pst = PWR_WAKE;
					ctl_nxt.wake_cnt = wake_load;
					ctl_nxt.pdown = 1'b0;
				end else if (cs_rise) begin
					ctl_nxt.pd_armed = 1'b1;
				end else if (start_rise && ctl_r.pd_armed) begin
					// first sclk edge of the next frame starts the power-up
					ctl_nxt.pst = PWR_WAKE;
					ctl_nxt.wake_cnt = wake_load;
					ctl_nxt.pdown = 1'b0;
				end
			end
			PWR_WAKE: begin
				if (ctl_r.wake_cnt <= 8'h01) begin
					ctl_nxt.pst = PWR_RUN;
					ctl_nxt.pup = 1'b1;
					ctl_nxt.wake_cnt = '0;
				end else begin
					ctl_nxt.wake_cnt = ctl_r.wake_cnt - 8'h01;
				end
			end
			default: begin
				ctl_nxt.pst = PWR_RUN;
				ctl_nxt.pdown = 1'b0;
				ctl_nxt.pup = 1'b1;
			end
		endcase

		// after the power case, so a running or waking state cannot keep powered_up high
		if (conv_done && ctl_r.pd_en) begin
			ctl_nxt.pst = PWR_DOWN;
			ctl_nxt.pdown = 1'b1;
			ctl_nxt.pup = 1'b0;
			ctl_nxt.pd_armed = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= '{
				cs_q: 1'b1,
				start_q: 1'b0,
				seen16: 1'b0,
				seen30: 1'b0,
				conv_cp: RES_ZERO,
				first_word: WORD_ZERO,
				valid_next: 1'b0,
				pd_en: 1'b0,
				pd_armed: 1'b0,
				pst: PWR_RUN,
				wake_cnt: 8'h00,
				hold: 1'b0,
				pdown: 1'b0,
				pup: 1'b1,
				mode32: 1'b0,
				dvalid: 1'b0,
				abort: 1'b0
			};
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign sdo = lnk_r.sdo;
	assign sdo_oe = lnk_r.oe;
	assign sample_hold = ctl_r.hold;
	assign power_down = ctl_r.pdown;
	assign powered_up = ctl_r.pup;
	assign frame_mode32 = ctl_r.mode32;
	assign frame_data_valid = ctl_r.dvalid;
	assign conv_abort = ctl_r.abort;

endmodule

`default_nettype wire

// [bench/sfp_core_checker.sv]
// assertions on the sequencer ports
// assumes: bound to sfp_core; host keeps cs_n high 8 mclk or more
`default_nettype none
module sfp_core_checker #(
	parameter int WAKE_CYCLES = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic sample_hold,
	input wire logic power_down,
	input wire logic powered_up,
	input wire logic frame_mode32,
	input wire logic frame_data_valid,
	input wire logic conv_abort
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------
	// properties
	// ------
	// slack for the synchroniser lag around the wake count
	localparam int WLO = WAKE_CYCLES - 1;
	localparam int WHI = WAKE_CYCLES + 3;
	sequence s_wake;
		!powered_up ##[WLO:WHI] powered_up;
	endsequence
	sequence s_take;
		##[1:4] sample_hold;
	endsequence
	property p_idle;
		@(posedge mclk) disable iff (!rst_n) cs_n |-> !sdo_oe && !sdo;
	endproperty
	property p_oe;
		@(posedge sclk) disable iff (!rst_n) sdo_oe |-> !cs_n;
	endproperty
	property p_take;
		@(posedge mclk) disable iff (!rst_n) $fell(cs_n) |-> s_take;
	endproperty
	property p_abort_one;
		@(posedge mclk) disable iff (!rst_n) conv_abort |=> !conv_abort;
	endproperty
	property p_abort_acq;
		@(posedge mclk) disable iff (!rst_n) conv_abort |-> cs_n && !sample_hold;
	endproperty
	property p_pd_entry;
		@(posedge mclk) disable iff (!rst_n) $rose(power_down) |-> !powered_up;
	endproperty
	property p_wake;
		@(posedge mclk) disable iff (!rst_n) $fell(power_down) |-> s_wake;
	endproperty
	property p_excl;
		@(posedge mclk) disable iff (!rst_n) !(power_down && powered_up);
	endproperty
	property p_mode;
		@(posedge mclk) disable iff (!rst_n) $changed(frame_mode32) |-> cs_n;
	endproperty
	property p_valid;
		@(posedge mclk) disable iff (!rst_n) $rose(frame_data_valid) |-> !cs_n;
	endproperty
	a_idle: assert property (p_idle) else $error("sdo live while idle");
	a_oe: assert property (p_oe) else $error("sdo_oe out of frame");
	a_take: assert property (p_take) else $error("no hold after cs fall");
	a_abort_one: assert property (p_abort_one) else $error("abort not a pulse");
	a_abort_acq: assert property (p_abort_acq) else $error("abort without acquire");
	a_pd_entry: assert property (p_pd_entry) else $error("powered at entry");
	a_wake: assert property (p_wake) else $error("wake time wrong");
	a_excl: assert property (p_excl) else $error("down and up together");
	a_mode: assert property (p_mode) else $error("mode changed in frame");
	a_valid: assert property (p_valid) else $error("valid set while idle");
endmodule

bind sfp_core sfp_core_checker #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.mclk, .rst_n, .sclk,
	.cs_n, .sdo, .sdo_oe, .sample_hold, .power_down, .powered_up, .frame_mode32,
	.frame_data_valid, .conv_abort);
`default_nettype wire

// [bench/sfp_host.sv]
// host spi master model: makes cs_n, sclk and the power-down request
// assumes: sclk parked low outside frames, bits taken on falling edges
`default_nettype none
module sfp_host (
	output logic sclk,
	output logic cs_n,
	output logic power_down_request,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		power_down_request = 1'b0;
	end
	// ------
	// one frame of n edges, 12 ns sclk
	// ------
	task automatic frame(input int n, input logic pd, output logic [31:0] w);
		w = '0;
		#3;
		cs_n = 1'b0;
		#14;
		// clock stops after the last edge
		for (int k = 0; k < n; k++) begin
			sclk = 1'b1;
			#6;
			sclk = 1'b0;
			if (k < 32)
				w[31-k] = sdo;
			#6;
		end
		power_down_request = pd;
		#5;
		cs_n = 1'b1;
		#200;
		// flip the request while idle, it must be ignored
		power_down_request = ~pd;
	endtask
endmodule
`default_nettype wire

// [bench/test_serial_adc_frame_power_control.sv]
// self-checking bench for the frame and power sequencer
// assumes: sfp_host plays the master; wake count cut to 4 mclk
`default_nettype none
module test_serial_adc_frame_power_control;
	timeunit 1ns;
	timeprecision 1ps;
	import sfp_pkg::*;
	logic mclk;
	logic rst_n;
	logic [RES_W-1:0] sample_code;
	logic sclk, cs_n, power_down_request, sdo, sdo_oe, sample_hold;
	logic power_down, powered_up, frame_mode32, frame_data_valid, conv_abort;
	logic [31:0] w;
	int n_fail = 0;
	int n_checks = 0;
	int n_abort = 0;
	int cyc = 0;
	sfp_core #(.WAKE_CYCLES(4)) u_dut (.mclk, .rst_n, .sclk, .cs_n, .power_down_request,
		.sample_code, .sdo, .sdo_oe, .sample_hold, .power_down, .powered_up,
		.frame_mode32, .frame_data_valid, .conv_abort);
	sfp_host u_host (.sclk, .cs_n, .power_down_request, .sdo);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// ------
	// helpers
	// ------
	task automatic final_report();
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			final_report();
		end
	end
	always @(posedge mclk)
		if (conv_abort === 1'b1)
			n_abort <= n_abort + 1;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [WORD_W-1:0] wd(input logic [RES_W-1:0] c);
		return {c, PAD_ZERO};
	endfunction
	task automatic fr(input int n, input logic pd, input logic [RES_W-1:0] c);
		@(posedge mclk);
		sample_code <= c;
		@(posedge mclk);
		u_host.frame(n, pd, w);
	endtask
	// ------
	// scenarios
	// ------
	task automatic t_burst();
		fr(16, 1'b0, 14'h2a5c);
		fr(29, 1'b0, 14'h1f03);
		check(w & 32'hffff_fff8, {wd(14'h2a5c), wd(14'h1f03)} & 32'hffff_fff8);
		check(frame_mode32, 1'b0);
		fr(16, 1'b0, 14'h0e71);
		check(w[31:16], wd(14'h1f03));
		check(frame_data_valid, 1'b1);
	endtask
	task automatic t_mode32();
		fr(32, 1'b0, 14'h3ffd);
		check(w, {wd(14'h0e71), wd(14'h3ffd)});
		check(frame_mode32, 1'b1);
		check(power_down, 1'b0);
		fr(16, 1'b0, 14'h0001);
		check(w[31:16], WORD_ZERO);
		check(frame_mode32, 1'b0);
	endtask
	task automatic t_abort();
		fr(8, 1'b0, 14'h1234);
		check(n_abort, 1);
		fr(16, 1'b0, 14'h2bcd);
		check(frame_data_valid, 1'b0);
		fr(16, 1'b0, 14'h0777);
		check(w[31:16], wd(14'h2bcd));
	endtask
	task automatic t_power();
		fr(16, 1'b1, 14'h0abc);
		check(power_down, 1'b0);
		fr(16, 1'b1, 14'h3210);
		check({power_down, powered_up}, 2'b10);
		fr(16, 1'b0, 14'h0003);
		check(w[31:16], wd(14'h3210));
		check({power_down, powered_up}, 2'b01);
	endtask
	initial begin
		rst_n = 1'b0;
		sample_code = RES_ZERO;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		check({sdo_oe, power_down, powered_up, frame_mode32, frame_data_valid}, 5'h04);
		t_burst();
		t_mode32();
		t_abort();
		t_power();
		final_report();
	end
endmodule
`default_nettype wire
